// ---- verilog/crcc_top.sv ----
// CRC calculator: registers, input buffer and CRC engine
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "crcc_cfg.svh"

// =====================================================================
// Flow through the block
// Control write picks polynomial and bit order
// Right-size data writes enter a two-entry buffer
// The engine folds one buffered unit per clock
// A right-size result write loads the seed and stalls the engine
// A right-size result read returns the masked CRC
// Limits
// Queued units use the select in force when folded,
// so software waits for busy to clear before reselecting
// Wrong-size data writes are dropped, never split
// Off codes drain queued units without effect
// Module stop ignores every access and reads zero
// Trade-off
// The step is fully unrolled: more area, no wait states
module crcc_top #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // Low-power control
  input  wire logic                 stop_i,
  // Register port
  input  wire logic [`CRCC_AW-1:0] addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic [1:0]           size_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic [31:0]               rdata_o,
  // Flow status
  output logic                      data_ready_o
);

  // =====================================================================
  // Parameter check
  if (BUF_DEPTH < 2) begin : g_chk
    $error("crcc_top: BUF_DEPTH must be at least 2");
  end

  // =====================================================================
  // State
  typedef struct packed {
    crcc_pkg::crcc_poly_t poly;  // Polynomial select field
    logic                 order; // Bit-order select, 1 = LSB first
    logic [31:0]          crc;   // Running CRC
    logic [31:0]          din;   // Last accepted input word
    logic [31:0]          rdata; // Read data, valid one cycle
  } crcc_top_st_t;

  crcc_top_st_t q_ff;  // Registered state
  crcc_top_st_t nxt_q; // Next state

  // =====================================================================
  // Decoded controls
  // Strobes below are already gated by module stop
  logic                 act;        // Not in module stop
  logic                 wr_ctrl;    // Control write
  logic                 wr_din;     // Data write with any size
  logic                 wr_res;     // Result write with any size
  logic                 rd_res;     // Result read with any size
  logic                 is32;       // A 32-bit polynomial is active
  logic                 poly_on;    // Calculation enabled
  logic                 din_sz_ok;  // Data write size fits the polynomial
  logic                 res_sz_ok;  // Result access size fits the width
  logic                 seed_wr;    // Accepted seed write
  crcc_pkg::crcc_size_t res_sz;     // Size the result expects
  logic [31:0]          cur_poly;   // Active polynomial
  logic [5:0]           cur_w;      // Active width in bits
  logic [31:0]          cur_mask;   // Active width mask

  // Buffer connections
  logic                 push;       // Entry offered to the buffer
  logic                 buf_rdy;    // Buffer can take an entry
  logic                 buf_valid;  // Entry waiting for the engine
  logic                 pop_rdy;    // Engine can take an entry
  logic                 pop;        // Entry taken this cycle
  logic [32:0]          buf_out;    // {long flag, data}
  logic [5:0]           step_bits;  // Bits in the entry taken
  logic [31:0]          step_crc;   // Engine result

  // =====================================================================
  // Polynomial decode
  // Off codes still carry a width so that seeds load as a longword
  // Each code maps to a polynomial, a width and a result size
  always_comb begin
    unique case (q_ff.poly)
      crcc_pkg::CRCC_P_8: begin
        cur_poly = `CRCC_POLY_8;
        cur_w    = `CRCC_BITS_BYTE;
        cur_mask = `CRCC_MASK_8;
        res_sz   = crcc_pkg::CRCC_SZ_BYTE;
        poly_on  = 1'b1;
      end
      crcc_pkg::CRCC_P_16A: begin
        cur_poly = `CRCC_POLY_16A;
        cur_w    = `CRCC_BITS_HALF;
        cur_mask = `CRCC_MASK_16;
        res_sz   = crcc_pkg::CRCC_SZ_HALF;
        poly_on  = 1'b1;
      end
      crcc_pkg::CRCC_P_16B: begin
        cur_poly = `CRCC_POLY_16B;
        cur_w    = `CRCC_BITS_HALF;
        cur_mask = `CRCC_MASK_16;
        res_sz   = crcc_pkg::CRCC_SZ_HALF;
        poly_on  = 1'b1;
      end
      crcc_pkg::CRCC_P_32A: begin
        cur_poly = `CRCC_POLY_32A;
        cur_w    = `CRCC_BITS_LONG;
        cur_mask = `CRCC_MASK_32;
        res_sz   = crcc_pkg::CRCC_SZ_LONG;
        poly_on  = 1'b1;
      end
      crcc_pkg::CRCC_P_32B: begin
        cur_poly = `CRCC_POLY_32B;
        cur_w    = `CRCC_BITS_LONG;
        cur_mask = `CRCC_MASK_32;
        res_sz   = crcc_pkg::CRCC_SZ_LONG;
        poly_on  = 1'b1;
      end
      crcc_pkg::CRCC_P_OFF,
      crcc_pkg::CRCC_P_OFF6,
      crcc_pkg::CRCC_P_OFF7: begin
        // No calculation for these codes
        cur_poly = `CRCC_POLY_32A;
        cur_w    = `CRCC_BITS_LONG;
        cur_mask = `CRCC_MASK_32;
        res_sz   = crcc_pkg::CRCC_SZ_LONG;
        poly_on  = 1'b0;
      end
    endcase
  end

  // =====================================================================
  // Bus decode
  // Everything is gated by module stop so the block stays frozen
  always_comb begin
    act       = ~stop_i;
    wr_ctrl   = act & wr_i & (addr_i == `CRCC_ADDR_CTRL);
    wr_din    = act & wr_i & (addr_i == `CRCC_ADDR_DIN);
    wr_res    = act & wr_i & (addr_i == `CRCC_ADDR_RES);
    rd_res    = act & rd_i & (addr_i == `CRCC_ADDR_RES);
    is32      = (q_ff.poly == crcc_pkg::CRCC_P_32A) ||
                (q_ff.poly == crcc_pkg::CRCC_P_32B);
    // Wrong-size input writes are dropped, not split or padded
    din_sz_ok = is32 ? (size_i == crcc_pkg::CRCC_SZ_LONG)
                     : (size_i == crcc_pkg::CRCC_SZ_BYTE);
    res_sz_ok = (size_i == res_sz);
    seed_wr   = wr_res & res_sz_ok;
    push      = wr_din & din_sz_ok;
    // A seed write takes the cycle, so queued data waits behind it
    pop_rdy   = act & ~seed_wr;
    pop       = buf_valid & pop_rdy;
    step_bits = buf_out[32] ? `CRCC_BITS_LONG : `CRCC_BITS_BYTE;
  end

  // =====================================================================
  // Input buffer
  // Holds written units so an engine stall loses no word
  // Bit 32 of an entry flags a longword unit
  crcc_buf #(
    .W     (33),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_rdy),
    .in_data_i   ({is32, is32 ? wdata_i : {24'h000000, wdata_i[7:0]}}),
    .out_valid_o (buf_valid),
    .out_ready_i (pop_rdy),
    .out_data_o  (buf_out)
  );

  // =====================================================================
  // CRC engine
  // Bit order picks the shift direction, the reflected or direct polynomial and the data bit order
  crcc_step u_step (
    .crc_i       (q_ff.crc),
    .data_i      (buf_out[31:0]),
    .nbits_i     (step_bits),
    .width_i     (cur_w),
    .poly_i      (cur_poly),
    .lsb_first_i (q_ff.order),
    .crc_o       (step_crc)
  );

  // =====================================================================
  // Next state
  always_comb begin
    nxt_q       = q_ff;
    nxt_q.rdata = `CRCC_RST_WORD;
    // Read data falls back to zero outside a read
    // Control write sets select and order
    if (wr_ctrl) begin
      nxt_q.poly  = crcc_pkg::crcc_poly_t'(wdata_i[`CRCC_CTRL_POLY_MSB:`CRCC_CTRL_POLY_LSB]);
      nxt_q.order = wdata_i[`CRCC_CTRL_ORDER_BIT];
    end
    // Accepted input is kept for read-back
    if (push && buf_rdy) begin
      nxt_q.din = is32 ? wdata_i : {24'h000000, wdata_i[7:0]};
    end
    // Fold one unit; disabled codes drain the entry without effect
    if (pop && poly_on) begin
      nxt_q.crc = step_crc;
    end
    // Seed load wins over the engine, which is stalled anyway
    if (seed_wr) begin
      nxt_q.crc = wdata_i & cur_mask;
    end
    // Read data for the next cycle only
    if (act && rd_i) begin
      unique case (addr_i)
        `CRCC_ADDR_CTRL: begin
          nxt_q.rdata[`CRCC_CTRL_POLY_MSB:`CRCC_CTRL_POLY_LSB] = q_ff.poly;
          nxt_q.rdata[`CRCC_CTRL_ORDER_BIT]                    = q_ff.order;
          nxt_q.rdata[`CRCC_CTRL_BUSY_BIT]                     = buf_valid;
        end
        `CRCC_ADDR_DIN: begin
          nxt_q.rdata = q_ff.din;
        end
        `CRCC_ADDR_RES: begin
          // Mismatched width reads zero; 8-bit result in the low byte
          if (res_sz_ok) begin
            nxt_q.rdata = q_ff.crc & cur_mask;
          end
        end
        default: begin
          // Unmapped addresses read zero
          nxt_q.rdata = `CRCC_RST_WORD;
        end
      endcase
    end
  end

  // =====================================================================
  // State register
  // Reset turns calculation off with a zero result
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff.poly  <= crcc_pkg::CRCC_P_OFF;
      q_ff.order <= `CRCC_RST_ORDER;
      q_ff.crc   <= `CRCC_RST_WORD;
      q_ff.din   <= `CRCC_RST_WORD;
      q_ff.rdata <= `CRCC_RST_WORD;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // =====================================================================
  // Outputs
  // Both come straight from flops
  assign rdata_o      = q_ff.rdata;
  assign data_ready_o = buf_rdy;

  // =====================================================================
  // Checks
  // All checks run on the bus clock and sleep through reset
  // They watch internal state, so they stay with the logic
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Off codes leave the running value alone
  a_off_hold : assert property (
    (act && !poly_on && !seed_wr) |=> $stable(q_ff.crc))
    else $error("crc changed while calculation disabled");

  // Module stop freezes state and blanks read data
  a_stop_freeze : assert property (
    stop_i |=> ($stable(q_ff.crc) && $stable(q_ff.poly) && rdata_o == '0))
    else $error("state moved during module stop");

  // No access is taken while stopped
  a_stop_bus : assert property (
    stop_i |-> (!push && !seed_wr && !wr_ctrl))
    else $error("access taken during module stop");

  // Seed lands masked to the active width
  a_seed_load : assert property (
    seed_wr |=> q_ff.crc == $past(wdata_i & cur_mask))
    else $error("seed write not loaded");

  // Seed cycle holds the engine back
  a_seed_stall : assert property (
    seed_wr |-> !pop)
    else $error("unit folded during seed load");

  // Wrong-size data never reaches the buffer
  a_size_drop : assert property (
    (wr_din && !din_sz_ok) |=> $stable(q_ff.din))
    else $error("wrong-size input accepted");

  // Longword units enter whole
  a_long_unit : assert property (
    (push && buf_rdy && is32) |=> q_ff.din == $past(wdata_i))
    else $error("longword unit not taken whole");

  // Byte units enter zero-extended
  a_byte_unit : assert property (
    (push && buf_rdy && !is32) |=> q_ff.din[31:8] == '0)
    else $error("byte unit carried extra bits");

  // 8-bit result reads back in the low byte
  a_byte_result : assert property (
    (rd_res && q_ff.poly == crcc_pkg::CRCC_P_8 && size_i == crcc_pkg::CRCC_SZ_BYTE)
    |=> (rdata_o[31:8] == '0 && rdata_o[7:0] == $past(q_ff.crc[7:0])))
    else $error("8-bit result not in low byte");

  // Wrong-size result reads return zero
  a_narrow_read : assert property (
    (rd_res && !res_sz_ok) |=> rdata_o == '0)
    else $error("wrong-size result read gave data");

  // Read data stands one cycle only
  a_read_pulse : assert property (
    !(act && rd_i) |=> rdata_o == '0)
    else $error("read data stood too long");

  // Control write stores select and order
  a_ctrl_store : assert property (
    wr_ctrl |=> (q_ff.poly == $past(wdata_i[`CRCC_CTRL_POLY_MSB:`CRCC_CTRL_POLY_LSB]) &&
                 q_ff.order == $past(wdata_i[`CRCC_CTRL_ORDER_BIT])))
    else $error("control write not stored");

  // One unit per clock, folded at once
  a_fold_step : assert property (
    (pop && poly_on && !seed_wr) |=> q_ff.crc == $past(step_crc))
    else $error("unit not folded in one step");

  // 8-bit CRC keeps its upper bits clear
  a_width_clean : assert property (
    (pop && poly_on && cur_w == `CRCC_BITS_BYTE) |=> q_ff.crc[31:8] == '0)
    else $error("8-bit crc has bits above its width");
endmodule

// ---- verilog/crcc_cfg.svh ----
// Register map, field positions, reset values and polynomials of the CRC calculator
//
// Overview of operation
// - Data taken in bytes, or longwords for 32-bit CRCs
// - Each unit folded in one step, 8 or 32
// - Select codes 000, 110, 111 disable calculation
// - Codes 001/010/011 choose CRC-8 and two CRC-16s
// - Codes 100/101 choose the two CRC-32 polynomials
// - Control bit 6 picks LSB-first or MSB-first order
// - Result access width follows the selected CRC width
// - 8-bit CRC sits in result bits 7 to 0
// - Module stop freezes the logic until released
`ifndef CRCC_CFG_SVH
`define CRCC_CFG_SVH

// =====================================================================
// Register addresses
`define CRCC_AW              4
`define CRCC_ADDR_CTRL       4'h0
`define CRCC_ADDR_DIN        4'h4
`define CRCC_ADDR_RES        4'h8

// =====================================================================
// Control register fields and reset values
`define CRCC_CTRL_POLY_LSB   0
`define CRCC_CTRL_POLY_MSB   2
`define CRCC_CTRL_ORDER_BIT  6
`define CRCC_CTRL_BUSY_BIT   7
`define CRCC_RST_ORDER       1'h0
`define CRCC_RST_WORD        32'h00000000

// =====================================================================
// Generator polynomials, top term left out
`define CRCC_POLY_8          32'h00000007
`define CRCC_POLY_16A        32'h00008005
`define CRCC_POLY_16B        32'h00001021
`define CRCC_POLY_32A        32'h04C11DB7
`define CRCC_POLY_32B        32'h1EDC6F41

// =====================================================================
// Widths and masks
`define CRCC_BITS_BYTE       6'h08
`define CRCC_BITS_HALF       6'h10
`define CRCC_BITS_LONG       6'h20
`define CRCC_MASK_8          32'h000000FF
`define CRCC_MASK_16         32'h0000FFFF
`define CRCC_MASK_32         32'hFFFFFFFF

`endif

// ---- verilog/crcc_pkg.sv ----
// Types shared by the CRC calculator modules
package crcc_pkg;
  // Access size on the register port
  typedef enum logic [1:0] {
    CRCC_SZ_BYTE = 2'h0,
    CRCC_SZ_HALF = 2'h1,
    CRCC_SZ_LONG = 2'h2
  } crcc_size_t;
  // Polynomial select codes
  typedef enum logic [2:0] {
    CRCC_P_OFF  = 3'h0,
    CRCC_P_8    = 3'h1,
    CRCC_P_16A  = 3'h2,
    CRCC_P_16B  = 3'h3,
    CRCC_P_32A  = 3'h4,
    CRCC_P_32B  = 3'h5,
    CRCC_P_OFF6 = 3'h6,
    CRCC_P_OFF7 = 3'h7
  } crcc_poly_t;
endpackage

// ---- verilog/crcc_buf.sv ----
// Two-entry valid/ready buffer between the data register and the CRC engine
`timescale 1ns/10ps
module crcc_buf #(
  parameter int W     = 33,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  // Filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap freely, so only powers of two are served
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("crcc_buf: DEPTH must be a power of two of at least 2");
  end

  // =====================================================================
  // State
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // Entries
    logic [AW-1:0]           wp;  // Write pointer
    logic [AW-1:0]           rp;  // Read pointer
    logic [AW:0]             cnt; // Occupancy
    logic                    rdy; // Room for one more
  } crcc_buf_st_t;

  crcc_buf_st_t q_ff;
  crcc_buf_st_t nxt_q;
  logic         push;
  logic         pop;

  // Next state: ready is registered so the top sees it from a flop
  always_comb begin
    nxt_q = q_ff;
    push  = in_valid_i & q_ff.rdy;
    pop   = (q_ff.cnt != '0) & out_ready_i;
    if (push) begin
      nxt_q.mem[q_ff.wp] = in_data_i;
      nxt_q.wp           = q_ff.wp + AW'(1);
    end
    if (pop) begin
      nxt_q.rp = q_ff.rp + AW'(1);
    end
    nxt_q.cnt = q_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    nxt_q.rdy = nxt_q.cnt != (AW+1)'(DEPTH);
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff     <= '0;
      q_ff.rdy <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign in_ready_o  = q_ff.rdy;
  assign out_valid_o = q_ff.cnt != '0;
  assign out_data_o  = q_ff.mem[q_ff.rp];

  // =====================================================================
  // Checks
  a_buf_full : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !q_ff.rdy |-> q_ff.cnt == (AW+1)'(DEPTH))
    else $error("buffer refuses while not full");
  a_buf_hold : assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_data_o)))
    else $error("stalled buffer output changed");
endmodule

// ---- verilog/crcc_step.sv ----
// One parallel CRC step over 8 or 32 data bits
`timescale 1ns/10ps
module crcc_step (
  // Running value and data
  input  wire logic [31:0] crc_i,
  input  wire logic [31:0] data_i,
  input  wire logic [5:0]  nbits_i,
  // Polynomial description
  input  wire logic [5:0]  width_i,
  input  wire logic [31:0] poly_i,
  input  wire logic        lsb_first_i,
  // Updated value
  output logic [31:0]      crc_o
);
  logic [31:0] c;    // Working value
  logic [31:0] rp;   // Reflected polynomial
  logic [31:0] mask; // Width mask
  logic        fb;   // Feedback bit
  int          k;    // Index scratch

  // Whole unit is unrolled into one cycle of logic
  always_comb begin
    c    = crc_i;
    rp   = '0;
    mask = '0;
    fb   = 1'b0;
    k    = 0;
    for (int j = 0; j < 32; j++) begin
      if (j < int'(width_i)) begin
        mask[j] = 1'b1;
        k       = int'(width_i) - 1 - j;
        rp[k[4:0]] = poly_i[j];
      end
    end
    // Stale bits above a narrower width would shift down in LSB-first order
    c = c & mask;
    for (int i = 0; i < 32; i++) begin
      if (i < int'(nbits_i)) begin
        if (lsb_first_i) begin
          // Reflected form, data taken from bit 0 up
          fb = c[0] ^ data_i[i];
          c  = c >> 1;
          if (fb) begin
            c = c ^ rp;
          end
        end else begin
          // Direct form, data taken from the top bit down
          k  = int'(width_i) - 1;
          fb = c[k[4:0]];
          k  = int'(nbits_i) - 1 - i;
          fb = fb ^ data_i[k[4:0]];
          c  = (c << 1) & mask;
          if (fb) begin
            c = c ^ poly_i;
          end
        end
      end
    end
    crc_o = c & mask;
  end
endmodule

// ---- dv/crcc_tb.sv ----
// Self-checking testbench for the CRC calculator
`timescale 1ns/10ps
`include "crcc_cfg.svh"
module testbench;
  // ===================================================================
  // Case table row: inputs only, the expected result is worked out
  typedef struct packed {
    logic [2:0]  sel;   // Polynomial select code
    logic        lsb;   // Bit order, 1 = LSB first
    logic [31:0] seed;  // Start value written to the result
    logic [31:0] dat;   // Message longword
  } crcc_row_t;

  // ===================================================================
  // Design ports
  logic        sys_clk_i;     // 100 ns clock
  logic        rst_n_i;       // Async reset, active low
  logic        stop_i;        // Module stop
  logic [3:0]  addr_i;        // Register address
  logic [31:0] wdata_i;       // Write data
  logic [1:0]  size_i;        // Access size
  logic        wr_i;          // Write strobe
  logic        rd_i;          // Read strobe
  logic [31:0] rdata_o;       // Read data
  logic        data_ready_o;  // Input buffer has room
  // Bench state
  int          n_mismatch;    // Failed compares
  int          num_checks;    // All compares
  int          cyc;           // Cycles since start
  crcc_row_t   rows [13];     // Ordinary cases
  logic [31:0] q;             // Read value
  logic [31:0] ex;            // Expected value

  crcc_top i_crcc_top (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .stop_i       (stop_i),
    .addr_i       (addr_i),
    .wdata_i      (wdata_i),
    .size_i       (size_i),
    .wr_i         (wr_i),
    .rd_i         (rd_i),
    .rdata_o      (rdata_o),
    .data_ready_o (data_ready_o)
  );

  // ===================================================================
  // Clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // The whole run needs well under 2000 cycles
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  // ===================================================================
  // Helpers
  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      n_mismatch = n_mismatch + 1;
    end
  endtask
  // One bus cycle, sampled at the following edge
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [1:0] s, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i    <= w;
    rd_i    <= r;
    addr_i  <= a;
    size_i  <= s;
    wdata_i <= d;
  endtask
  // Read: data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [1:0] s, output logic [31:0] d);
    bus(1'b0, 1'b1, a, s, 32'h00000000);
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
    end
  endtask
  function automatic int wid(input logic [2:0] sel);
    case (sel)
      3'h1:    return 8;
      3'h2,
      3'h3:    return 16;
      3'h4,
      3'h5:    return 32;
      default: return 0;
    endcase
  endfunction
  function automatic logic [31:0] pol(input logic [2:0] sel);
    case (sel)
      3'h1:    return 32'h00000007;
      3'h2:    return 32'h00008005;
      3'h3:    return 32'h00001021;
      3'h4:    return 32'h04C11DB7;
      default: return 32'h1EDC6F41;
    endcase
  endfunction
  function automatic logic [31:0] msk(input int w);
    return (w == 8) ? 32'h000000FF : (w == 16) ? 32'h0000FFFF : 32'hFFFFFFFF;
  endfunction
  // Result access size follows the CRC width
  function automatic logic [1:0] rsz(input int w);
    return (w == 8) ? 2'h0 : (w == 16) ? 2'h1 : 2'h2;
  endfunction
  // Bitwise reference; LSB first runs the reflected register
  function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] d, input int nb,
                                          input int w, input logic [31:0] p, input logic lsb);
    logic [31:0] rp;
    logic        fb;
    rp = 32'h00000000;
    for (int i = 0; i < w; i++) rp[w-1-i] = p[i];
    for (int i = 0; i < nb; i++) begin
      if (lsb) begin
        fb = c[0] ^ d[i];
        c  = c >> 1;
        if (fb) c = c ^ rp;
      end else begin
        fb = c[w-1] ^ d[nb-1-i];
        c  = (c << 1) & msk(w);
        if (fb) c = c ^ p;
      end
    end
    return c;
  endfunction
  // Select, seed, feed the message (two longwords at 32 bits, else four bytes), read the result
  task automatic run_row(input crcc_row_t r);
    int          w;
    logic [31:0] p;
    w  = wid(r.sel);
    p  = pol(r.sel);
    ex = r.seed & msk(w);
    bus(1'b1, 1'b0, `CRCC_ADDR_CTRL, 2'h0, {25'h0, r.lsb, 3'h0, r.sel});
    bus(1'b1, 1'b0, `CRCC_ADDR_RES, rsz(w), ex);
    if (w == 32) begin
      bus(1'b1, 1'b0, `CRCC_ADDR_DIN, 2'h2, r.dat);
      bus(1'b1, 1'b0, `CRCC_ADDR_DIN, 2'h2, ~r.dat);
      ex = crc_ref(crc_ref(ex, r.dat, 32, w, p, r.lsb), ~r.dat, 32, w, p, r.lsb);
    end else begin
      for (int k = 0; k < 4; k++) begin
        bus(1'b1, 1'b0, `CRCC_ADDR_DIN, 2'h0, {24'h0, r.dat[8*k+:8]});
        if (w != 0) ex = crc_ref(ex, {24'h0, r.dat[8*k+:8]}, 8, w, p, r.lsb);
      end
    end
    idle(3);
    rd(`CRCC_ADDR_RES, rsz(w), q);
  endtask

  // ===================================================================
  // Main sequence
  initial begin
    rst_n_i = 1'b0; stop_i = 1'b0; addr_i = 4'h0; wdata_i = 32'h00000000;
    size_i = 2'h0; wr_i = 1'b0; rd_i = 1'b0;
    n_mismatch = 0; num_checks = 0; cyc = 0;
    for (int i = 0; i < 10; i++)
      rows[i] = '{sel: 3'(i / 2 + 1), lsb: 1'(i % 2), seed: (i % 3 == 0) ? 32'h00000000 : 32'hA5C35A3C,
                  dat: 32'h31323334 + 32'(i) * 32'h01010101};
    rows[10] = '{sel: 3'h0, lsb: 1'b0, seed: 32'h13579BDF, dat: 32'h55AA00FF};
    rows[11] = '{sel: 3'h6, lsb: 1'b1, seed: 32'h2468ACE0, dat: 32'h0F0F0F0F};
    rows[12] = '{sel: 3'h7, lsb: 1'b0, seed: 32'hFEDCBA98, dat: 32'h12345678};
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    // Reset state: calculation off, result zero, room in the buffer
    chk({31'h0, data_ready_o}, 32'h00000001);
    rd(`CRCC_ADDR_CTRL, 2'h0, q);
    chk(q, 32'h00000000);
    rd(`CRCC_ADDR_RES, 2'h2, q);
    chk(q, 32'h00000000);
    // Table: every select code, both bit orders, seeded start
    for (int i = 0; i < 13; i++) begin
      run_row(rows[i]);
      chk(q, ex);
      rd(`CRCC_ADDR_CTRL, 2'h0, q);
      chk(q, {25'h0, rows[i].lsb, 3'h0, rows[i].sel});
    end
    // Byte data under a 32-bit select is dropped
    bus(1'b1, 1'b0, `CRCC_ADDR_CTRL, 2'h0, 32'h00000004);
    bus(1'b1, 1'b0, `CRCC_ADDR_RES, 2'h2, 32'h12345678);
    bus(1'b1, 1'b0, `CRCC_ADDR_DIN, 2'h0, 32'h000000AB);
    idle(3);
    rd(`CRCC_ADDR_RES, 2'h2, q);
    chk(q, 32'h12345678);
    // Read-back still holds the last byte of the final table row
    rd(`CRCC_ADDR_DIN, 2'h2, q);
    chk(q, 32'h00000012);
    // Longword data under an 8-bit select is dropped
    bus(1'b1, 1'b0, `CRCC_ADDR_CTRL, 2'h0, 32'h00000001);
    bus(1'b1, 1'b0, `CRCC_ADDR_RES, 2'h0, 32'h0000005A);
    bus(1'b1, 1'b0, `CRCC_ADDR_DIN, 2'h2, 32'hDEADBEEF);
    idle(3);
    rd(`CRCC_ADDR_RES, 2'h0, q);
    chk(q, 32'h0000005A);
    // Result read wider than the CRC gives nothing
    rd(`CRCC_ADDR_RES, 2'h2, q);
    chk(q, 32'h00000000);
    // Module stop: writes ignored, reads zero, state kept
    @(posedge sys_clk_i);
    stop_i <= 1'b1;
    bus(1'b1, 1'b0, `CRCC_ADDR_DIN, 2'h0, 32'h00000031);
    rd(`CRCC_ADDR_CTRL, 2'h0, q);
    chk(q, 32'h00000000);
    @(posedge sys_clk_i);
    stop_i <= 1'b0;
    idle(3);
    rd(`CRCC_ADDR_RES, 2'h0, q);
    chk(q, 32'h0000005A);
    // Eight bytes back to back through the buffer, 16-bit MSB first
    bus(1'b1, 1'b0, `CRCC_ADDR_CTRL, 2'h0, 32'h00000002);
    bus(1'b1, 1'b0, `CRCC_ADDR_RES, 2'h1, 32'h0000FFFF);
    ex = 32'h0000FFFF;
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 1'b0, `CRCC_ADDR_DIN, 2'h0, 32'(8'hC0 + k));
      ex = crc_ref(ex, 32'(8'hC0 + k), 8, 16, 32'h00008005, 1'b0);
    end
    // Last unit still queued: busy shows beside select 010
    rd(`CRCC_ADDR_CTRL, 2'h0, q);
    chk(q, 32'h00000082);
    idle(1);
    chk({31'h0, data_ready_o}, 32'h00000001);
    idle(3);
    rd(`CRCC_ADDR_RES, 2'h1, q);
    chk(q, ex);
    // Reset in mid-run clears select, order and result
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(`CRCC_ADDR_CTRL, 2'h0, q);
    chk(q, 32'h00000000);
    rd(`CRCC_ADDR_RES, 2'h2, q);
    chk(q, 32'h00000000);
    end_sim();
  end
endmodule
